//--- core/cbs_cfg.svh
`ifndef CBS_CFG_SVH
`define CBS_CFG_SVH

// ==========================================================
// internal state counts
`define CBS_DIV_B_STATES 5'd11
`define CBS_DIV_W_STATES 5'd19
`define CBS_ONE_STATE 5'd1

// ==========================================================
// sequence table geometry
`define CBS_MAX_STEPS 8
`define CBS_IDX_W 3

// ==========================================================
// reset values
`define CBS_RST_IDX 3'h0
`define CBS_RST_REP 8'h00

`endif

//--- core/cbs_pkg.sv
`include "cbs_cfg.svh"

package cbs_pkg;

	// ==========================================================
	// instruction classes covered by the sequencer
	typedef enum logic [4:0] {
		CBS_OP_NEXT_ONLY,    // compare reg, dec, inc, cc/ext reg loads
		CBS_OP_CMP_IMM32,    // long compare with 32-bit immediate
		CBS_OP_LDC_IMM_EXT,  // immediate load of extended_control_reg
		CBS_OP_SDIV_B,       // signed_divide byte
		CBS_OP_SDIV_W,       // signed_divide word
		CBS_OP_UDIV_B,       // unsigned_divide byte
		CBS_OP_UDIV_W,       // unsigned_divide word
		CBS_OP_BLOCK_MOVE,   // block transfer, n bytes
		CBS_OP_JMP_REG,      // jump register indirect
		CBS_OP_JMP_ABS24,    // jump absolute 24-bit
		CBS_OP_JMP_VEC8,     // jump memory indirect via 8-bit vector
		CBS_OP_JSR_REG,      // subroutine_call register indirect
		CBS_OP_JSR_ABS24,    // subroutine_call absolute 24-bit
		CBS_OP_JSR_VEC8,     // subroutine_call via 8-bit vector
		CBS_OP_LDC_IND,      // control_register_load register indirect
		CBS_OP_LDC_D16,      // with 16-bit displacement
		CBS_OP_LDC_D32,      // with 32-bit displacement
		CBS_OP_LDC_POSTINC,  // post increment
		CBS_OP_LDC_ABS16,    // absolute 16-bit
		CBS_OP_LDC_ABS32,    // absolute 32-bit
		CBS_OP_POP_MULTI     // multi_register_pop
	} cbs_op_e;

	// ==========================================================
	// kind of one column of a sequence
	typedef enum logic [1:0] {
		CBS_SK_END,
		CBS_SK_READ,
		CBS_SK_WRITE,
		CBS_SK_IDLE
	} cbs_kind_e;

	// ==========================================================
	// what a bus cycle addresses
	typedef enum logic [3:0] {
		CBS_TG_NONE,
		CBS_TG_NEXT,   // next instruction word
		CBS_TG_EXT2,   // 2nd instruction word
		CBS_TG_EXT3,
		CBS_TG_EXT4,
		CBS_TG_EXT5,
		CBS_TG_EA,     // effective_address_access
		CBS_TG_EAS,    // block source
		CBS_TG_EAD,    // block destination
		CBS_TG_VEC,    // 8-bit vector location
		CBS_TG_STK_H,  // stack high word
		CBS_TG_STK_L   // stack low word (or sole word of a normal-mode push)
	} cbs_tgt_e;

	typedef enum logic [1:0] {
		CBS_PH_IDLE,
		CBS_PH_STEP,
		CBS_PH_BUS,
		CBS_PH_INT
	} cbs_phase_e;

	// one column of a sequence
	typedef struct packed {
		cbs_kind_e kind;
		logic byte_sz;
		logic lock;
		cbs_tgt_e tgt;
		logic [4:0] states;
		logic loop_first;
		logic loop_last;
	} cbs_step_s;

	// whole state of the sequencer
	typedef struct packed {
		cbs_phase_e phase;
		cbs_op_e op;
		logic adv;
		logic [`CBS_IDX_W-1:0] idx;
		logic [7:0] rep;
		logic req;
		logic wr;
		logic byte_sz;
		logic lock;
		cbs_tgt_e tgt;
		logic idle;
		logic busy;
		logic done;
	} cbs_state_s;

	// whole state of the idle timer
	typedef struct packed {
		logic [4:0] rem;
	} cbs_tmr_s;

endpackage

//--- core/cbs_tmr_if.sv
// ==========================================================
// link between sequencer and its internal-state timer
interface cbs_tmr_if;
	logic load;         // one-cycle pulse, start counting
	logic [4:0] count;  // number of internal states
	logic last;         // current state is the final one
	modport seq (output load, output count, input last);
	modport tmr (input load, input count, output last);
endinterface

//--- core/cbs_idle_timer.sv
module cbs_idle_timer
	import cbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	cbs_tmr_if.tmr tmr_io
);

	cbs_tmr_s q;  // registered state
	cbs_tmr_s d;  // next state

	// ==========================================================
	// countdown: loaded with n, flags last while rem is one
	always_comb begin
		d = q;
		if (tmr_io.load) begin
			d.rem = tmr_io.count;
		end else if (q.rem != 5'h00) begin
			d.rem = q.rem - 5'h01;
		end
	end

	// last is decoded from a flop, so no loop back into the loader
	assign tmr_io.last = (q.rem == 5'h01);

	// ==========================================================
	// state register
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

//--- core/cbs_sequencer.sv
// How it works
// - byte divide: 11 internal states after fetches
// - word divide: 19 internal states after fetches
// - advanced call: locked high push, then low
// - vector jump: vector read (locked word pair in advanced mode), one state, target
// - block move: n+1 source/dest byte pairs, fetch
// - multi pop: one state, locked H then L
`include "cbs_cfg.svh"

module cbs_sequencer
	import cbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire cbs_op_e op_in,
	input wire logic adv_mode_in,
	input wire logic [7:0] count_in,
	input wire logic bus_ack_in,
	output logic bus_req_out,
	output logic bus_write_out,
	output logic bus_byte_out,
	output logic bus_lock_out,
	output cbs_tgt_e bus_target_out,
	output logic idle_out,
	output logic busy_out,
	output logic done_out
);

	// ==========================================================
	// column builders
	function automatic cbs_step_s bus_col(input logic wr,
		input logic byte_sz, input logic lock, input cbs_tgt_e tgt);
		cbs_step_s s;
		s = '0;
		s.kind = wr ? CBS_SK_WRITE : CBS_SK_READ;
		s.byte_sz = byte_sz;
		s.lock = lock;
		s.tgt = tgt;
		return s;
	endfunction

	function automatic cbs_step_s rd(input cbs_tgt_e tgt);
		return bus_col(1'b0, 1'b0, 1'b0, tgt);
	endfunction

	function automatic cbs_step_s idle_col(input logic [4:0] n);
		cbs_step_s s;
		s = '0;
		s.kind = CBS_SK_IDLE;
		s.states = n;
		return s;
	endfunction

	// ==========================================================
	// sequence table: column idx of instruction op in given mode;
	// unused columns stay at end-of-sequence
	function automatic cbs_step_s step_at(input cbs_op_e op,
		input logic adv, input logic [`CBS_IDX_W-1:0] idx);
		cbs_step_s seq [`CBS_MAX_STEPS];
		for (int i = 0; i < `CBS_MAX_STEPS; i++) begin
			seq[i] = '0;
		end
		unique case (op)
			CBS_OP_NEXT_ONLY: begin
				seq[0] = rd(CBS_TG_NEXT);
			end
			CBS_OP_CMP_IMM32: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_EXT3);
				seq[2] = rd(CBS_TG_NEXT);
			end
			CBS_OP_LDC_IMM_EXT: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_NEXT);
			end
			CBS_OP_SDIV_B: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_NEXT);
				seq[2] = idle_col(`CBS_DIV_B_STATES);
			end
			CBS_OP_SDIV_W: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_NEXT);
				seq[2] = idle_col(`CBS_DIV_W_STATES);
			end
			CBS_OP_UDIV_B: begin
				seq[0] = rd(CBS_TG_NEXT);
				seq[1] = idle_col(`CBS_DIV_B_STATES);
			end
			CBS_OP_UDIV_W: begin
				seq[0] = rd(CBS_TG_NEXT);
				seq[1] = idle_col(`CBS_DIV_W_STATES);
			end
			CBS_OP_BLOCK_MOVE: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = bus_col(1'b0, 1'b1, 1'b0, CBS_TG_EAS);
				seq[2] = bus_col(1'b0, 1'b1, 1'b0, CBS_TG_EAD);
				// repeated pair: source read, destination write
				seq[3] = bus_col(1'b0, 1'b1, 1'b0, CBS_TG_EAS);
				seq[3].loop_first = 1'b1;
				seq[4] = bus_col(1'b1, 1'b1, 1'b0, CBS_TG_EAD);
				seq[4].loop_last = 1'b1;
				seq[5] = rd(CBS_TG_NEXT);
			end
			CBS_OP_JMP_REG: begin
				seq[0] = rd(CBS_TG_NEXT);
				seq[1] = rd(CBS_TG_EA);
			end
			CBS_OP_JMP_ABS24: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = idle_col(`CBS_ONE_STATE);
				seq[2] = rd(CBS_TG_EA);
			end
			CBS_OP_JMP_VEC8: begin
				seq[0] = rd(CBS_TG_NEXT);
				if (adv) begin
					// 32-bit vector: locked pair of word reads
					seq[1] = bus_col(1'b0, 1'b0, 1'b1, CBS_TG_VEC);
					seq[2] = rd(CBS_TG_VEC);
					seq[3] = idle_col(`CBS_ONE_STATE);
					seq[4] = rd(CBS_TG_EA);
				end else begin
					seq[1] = rd(CBS_TG_VEC);
					seq[2] = idle_col(`CBS_ONE_STATE);
					seq[3] = rd(CBS_TG_EA);
				end
			end
			CBS_OP_JSR_REG, CBS_OP_JSR_ABS24: begin
				seq[0] = (op == CBS_OP_JSR_REG) ? rd(CBS_TG_NEXT) :
					rd(CBS_TG_EXT2);
				// absolute form spends one state before the target
				seq[1] = (op == CBS_OP_JSR_REG) ? rd(CBS_TG_EA) :
					idle_col(`CBS_ONE_STATE);
				seq[2] = (op == CBS_OP_JSR_REG) ? '0 : rd(CBS_TG_EA);
				if (op == CBS_OP_JSR_REG) begin
					seq[2] = bus_col(1'b1, 1'b0, adv,
						adv ? CBS_TG_STK_H : CBS_TG_STK_L);
					seq[3] = adv ?
						bus_col(1'b1, 1'b0, 1'b0, CBS_TG_STK_L) : '0;
				end else begin
					seq[3] = bus_col(1'b1, 1'b0, adv,
						adv ? CBS_TG_STK_H : CBS_TG_STK_L);
					seq[4] = adv ?
						bus_col(1'b1, 1'b0, 1'b0, CBS_TG_STK_L) : '0;
				end
			end
			CBS_OP_JSR_VEC8: begin
				seq[0] = rd(CBS_TG_NEXT);
				if (adv) begin
					seq[1] = bus_col(1'b0, 1'b0, 1'b1, CBS_TG_VEC);
					seq[2] = rd(CBS_TG_VEC);
					seq[3] = bus_col(1'b1, 1'b0, 1'b1, CBS_TG_STK_H);
					seq[4] = bus_col(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
					seq[5] = rd(CBS_TG_EA);
				end else begin
					seq[1] = rd(CBS_TG_VEC);
					seq[2] = bus_col(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
					seq[3] = rd(CBS_TG_EA);
				end
			end
			CBS_OP_LDC_IND: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_NEXT);
				seq[2] = rd(CBS_TG_EA);
			end
			CBS_OP_LDC_D16, CBS_OP_LDC_ABS16: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_EXT3);
				seq[2] = rd(CBS_TG_NEXT);
				seq[3] = rd(CBS_TG_EA);
			end
			CBS_OP_LDC_D32: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_EXT3);
				seq[2] = rd(CBS_TG_EXT4);
				seq[3] = rd(CBS_TG_EXT5);
				seq[4] = rd(CBS_TG_NEXT);
				seq[5] = rd(CBS_TG_EA);
			end
			CBS_OP_LDC_POSTINC: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_NEXT);
				seq[2] = idle_col(`CBS_ONE_STATE);
				seq[3] = rd(CBS_TG_EA);
			end
			CBS_OP_LDC_ABS32: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = rd(CBS_TG_EXT3);
				seq[2] = rd(CBS_TG_EXT4);
				seq[3] = rd(CBS_TG_NEXT);
				seq[4] = rd(CBS_TG_EA);
			end
			CBS_OP_POP_MULTI: begin
				seq[0] = rd(CBS_TG_EXT2);
				seq[1] = bus_col(1'b0, 1'b0, 1'b1, CBS_TG_NEXT);
				seq[2] = idle_col(`CBS_ONE_STATE);
				// one locked high / low pair per register
				seq[3] = bus_col(1'b0, 1'b0, 1'b1, CBS_TG_STK_H);
				seq[3].loop_first = 1'b1;
				seq[4] = rd(CBS_TG_STK_L);
				seq[4].loop_last = 1'b1;
			end
			default: begin
				seq[0] = '0;  // unused op codes end at once
			end
		endcase
		return seq[idx];
	endfunction

	// ==========================================================
	// state and links
	cbs_state_s q;    // registered state
	cbs_state_s d;    // next state
	cbs_step_s st;    // current column
	cbs_tmr_if tmr_io ();

	cbs_idle_timer u_timer (
		.clk_in(clk_in),
		.srst_in(srst_in),
		.tmr_io(tmr_io.tmr)
	);

	assign st = step_at(q.op, q.adv, q.idx);

	// ==========================================================
	// sequencing: one dispatch cycle, then the column itself
	always_comb begin
		d = q;
		d.done = 1'b0;
		tmr_io.load = 1'b0;
		tmr_io.count = st.states;
		unique case (q.phase)
			CBS_PH_IDLE: begin
				// op and count are caught once; later input changes ignored
				if (start_in) begin
					d.op = op_in;
					d.adv = adv_mode_in;
					d.rep = count_in;
					d.idx = `CBS_RST_IDX;
					d.busy = 1'b1;
					d.phase = CBS_PH_STEP;
				end
			end
			CBS_PH_STEP: begin
				if (st.kind == CBS_SK_END) begin
					d.busy = 1'b0;
					d.done = 1'b1;
					d.phase = CBS_PH_IDLE;
				end else if (st.loop_first && q.rep == 8'h00) begin
					// zero repeats: skip the whole pair
					d.idx = q.idx + 3'h2;
				end else if (st.kind == CBS_SK_IDLE) begin
					tmr_io.load = 1'b1;
					d.idle = 1'b1;
					d.phase = CBS_PH_INT;
				end else begin
					d.req = 1'b1;
					d.wr = (st.kind == CBS_SK_WRITE);
					d.byte_sz = st.byte_sz;
					d.lock = st.lock;
					d.tgt = st.tgt;
					d.phase = CBS_PH_BUS;
				end
			end
			CBS_PH_BUS, CBS_PH_INT: begin
				// a column ends on its ack or its final internal state
				if ((q.phase == CBS_PH_BUS && bus_ack_in) ||
					(q.phase == CBS_PH_INT && tmr_io.last)) begin
					d.req = 1'b0;
					d.wr = 1'b0;
					d.byte_sz = 1'b0;
					d.lock = 1'b0;
					d.tgt = CBS_TG_NONE;
					d.idle = 1'b0;
					d.phase = CBS_PH_STEP;
					if (st.loop_last && q.rep > 8'h01) begin
						d.rep = q.rep - 8'h01;
						d.idx = q.idx - 3'h1;
					end else begin
						d.idx = q.idx + 3'h1;
					end
				end
			end
		endcase
	end

	// ==========================================================
	// state register; every output is a field of it
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign bus_req_out = q.req;
	assign bus_write_out = q.wr;
	assign bus_byte_out = q.byte_sz;
	assign bus_lock_out = q.lock;
	assign bus_target_out = q.tgt;
	assign idle_out = q.idle;
	assign busy_out = q.busy;
	assign done_out = q.done;

endmodule

//--- sim/cbs_sequencer_monitor.sv
module cbs_sequencer_monitor
	import cbs_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic start_in,
	input wire cbs_op_e op_in,
	input wire logic adv_mode_in,
	input wire logic [7:0] count_in,
	input wire logic bus_ack_in,
	input wire logic bus_req_out,
	input wire logic bus_write_out,
	input wire logic bus_byte_out,
	input wire logic bus_lock_out,
	input wire cbs_tgt_e bus_target_out,
	input wire logic idle_out,
	input wire logic busy_out,
	input wire logic done_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// helpers: op in flight and length of the running idle stretch
	cbs_op_e op_q;
	logic [4:0] run_q;
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			op_q <= CBS_OP_NEXT_ONLY;
			run_q <= 5'h00;
		end else begin
			if (start_in && !busy_out)
				op_q <= op_in;
			run_q <= idle_out ? run_q + 5'h01 : 5'h00;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	// ====
	// assertions
	div_byte_a: assert property ($fell(idle_out) && (op_q == CBS_OP_SDIV_B
		|| op_q == CBS_OP_UDIV_B) |-> run_q == 5'h0B) else $error("byte div");
	div_word_a: assert property ($fell(idle_out) && (op_q == CBS_OP_SDIV_W
		|| op_q == CBS_OP_UDIV_W) |-> run_q == 5'h13) else $error("word div");
	vec_gap_a: assert property (bus_req_out && bus_ack_in && !bus_lock_out
		&& bus_target_out == CBS_TG_VEC && op_q == CBS_OP_JMP_VEC8
		|=> !bus_req_out ##1 idle_out ##1 !idle_out && !bus_req_out
		##1 bus_req_out && bus_target_out == CBS_TG_EA) else $error("vec jump");
	push_lock_a: assert property (bus_req_out && bus_write_out
		&& bus_target_out == CBS_TG_STK_H |-> bus_lock_out) else $error("push");
	push_pair_a: assert property (bus_req_out && bus_ack_in && bus_write_out
		&& bus_target_out == CBS_TG_STK_H |=> ##1 bus_req_out && bus_write_out
		&& bus_target_out == CBS_TG_STK_L) else $error("push low");
	block_pair_a: assert property (bus_req_out && bus_ack_in
		&& bus_target_out == CBS_TG_EAS |=> ##1 bus_req_out && bus_byte_out
		&& bus_target_out == CBS_TG_EAD) else $error("block pair");
	pop_pair_a: assert property (bus_req_out && bus_ack_in && !bus_write_out
		&& bus_target_out == CBS_TG_STK_H |-> bus_lock_out ##2 bus_req_out
		&& !bus_lock_out && bus_target_out == CBS_TG_STK_L) else $error("pop");
	req_hold_a: assert property (bus_req_out && !bus_ack_in |=> bus_req_out
		&& $stable(bus_target_out) && $stable(bus_write_out)) else $error("hold");
	ack_gap_a: assert property (bus_req_out && bus_ack_in
		|=> !bus_req_out && !idle_out) else $error("dead cycle");
	done_pulse_a: assert property (done_out
		|-> !busy_out ##1 !done_out) else $error("done pulse");
	start_take_a: assert property (start_in && !busy_out
		|=> busy_out) else $error("start not taken");
	cover property (bus_req_out && !bus_write_out
		&& bus_target_out == CBS_TG_STK_H);
	cover property (done_out && op_q == CBS_OP_UDIV_W);
	cover property (bus_req_out && bus_write_out && bus_lock_out);
	cover property (bus_req_out && bus_write_out && bus_target_out == CBS_TG_EAD);
endmodule

bind cbs_sequencer cbs_sequencer_monitor i_mon (.clk_in(clk_in),
	.srst_in(srst_in), .start_in(start_in), .op_in(op_in),
	.adv_mode_in(adv_mode_in), .count_in(count_in), .bus_ack_in(bus_ack_in),
	.bus_req_out(bus_req_out), .bus_write_out(bus_write_out),
	.bus_byte_out(bus_byte_out), .bus_lock_out(bus_lock_out),
	.bus_target_out(bus_target_out), .idle_out(idle_out),
	.busy_out(busy_out), .done_out(done_out));

//--- sim/cbs_mem_model.sv
module cbs_mem_model (
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic req_in,
	input wire logic [3:0] wait_in,
	output logic ack_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] cnt_q;
	// memory answers after wait_in wait cycles, one-cycle acknowledge
	always @(negedge clk_in) begin
		if (srst_in || !req_in || ack_out) begin
			ack_out <= 1'b0;
			cnt_q <= 4'h0;
		end else if (cnt_q == wait_in)
			ack_out <= 1'b1;
		else
			cnt_q <= cnt_q + 4'h1;
	end
endmodule

//--- sim/tb_cbs_sequencer.sv
module tb_cbs_sequencer
	import cbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic start_in = 1'b0;
	cbs_op_e op_in = CBS_OP_NEXT_ONLY;
	logic adv_mode_in = 1'b0;
	logic [7:0] count_in = 8'h00;
	logic [3:0] wait_q = 4'h0;
	logic bus_ack_in, bus_req_out, bus_write_out, bus_byte_out, bus_lock_out;
	logic idle_out, busy_out, done_out;
	cbs_tgt_e bus_target_out;
	int errors = 0;
	int cmp_count = 0;
	logic [15:0] obs[$];
	logic [15:0] exp_q[$];
	logic [4:0] run = 5'h00;
	always #2 clk_in = ~clk_in;
	cbs_sequencer i_dut (.clk_in(clk_in), .srst_in(srst_in),
		.start_in(start_in), .op_in(op_in), .adv_mode_in(adv_mode_in),
		.count_in(count_in), .bus_ack_in(bus_ack_in),
		.bus_req_out(bus_req_out), .bus_write_out(bus_write_out),
		.bus_byte_out(bus_byte_out), .bus_lock_out(bus_lock_out),
		.bus_target_out(bus_target_out), .idle_out(idle_out),
		.busy_out(busy_out), .done_out(done_out));
	cbs_mem_model i_mem (.clk_in(clk_in), .srst_in(srst_in),
		.req_in(bus_req_out), .wait_in(wait_q), .ack_out(bus_ack_in));
	// ====
	// recorder: one entry per taken bus cycle or idle stretch
	always @(posedge clk_in) begin
		if (bus_req_out === 1'b1 && bus_ack_in === 1'b1)
			obs.push_back({1'b0, bus_write_out, bus_byte_out, bus_lock_out,
				bus_target_out, 8'h00});
		if (idle_out === 1'b1)
			run++;
		else if (run != 5'h00) begin
			obs.push_back({11'h400, run});
			run = 5'h00;
		end
	end
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cmp_col(input logic [15:0] g, input logic [15:0] x);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("CHECK FAILED %0t column %h want %h", $time, g, x);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic x, input string m);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// expected columns: bus cycle, plain word read, idle stretch
	task automatic e(input logic w, b, m, input cbs_tgt_e t);
		exp_q.push_back({1'b0, w, b, m, t, 8'h00});
	endtask
	task automatic r(input cbs_tgt_e t);
		e(1'b0, 1'b0, 1'b0, t);
	endtask
	task automatic ei(input logic [4:0] n);
		exp_q.push_back({11'h400, n});
	endtask
	// one instruction; bounded wait for done, then compare columns
	task automatic run_op(input cbs_op_e op, input logic adv,
		input logic [7:0] n, input logic [3:0] w);
		int i;
		@(negedge clk_in);
		obs.delete();
		wait_q = w;
		op_in = op;
		adv_mode_in = adv;
		count_in = n;
		start_in = 1'b1;
		@(negedge clk_in);
		start_in = 1'b0;
		cmp_bit(busy_out, 1'b1, "busy");
		for (i = 0; i < 600 && done_out !== 1'b1; i++)
			@(negedge clk_in);
		if (i == 600) begin
			errors++;
			$display("CHECK FAILED %0t no done", $time);
			final_report();
		end
		cmp_bit(busy_out, 1'b0, "busy end");
		cmp_col(16'(obs.size()), 16'(exp_q.size()));
		foreach (exp_q[k])
			if (k < obs.size())
				cmp_col(obs[k], exp_q[k]);
		exp_q.delete();
		// done is a one-cycle pulse
		@(negedge clk_in);
		cmp_bit(done_out, 1'b0, "done pulse");
	endtask
	// ====
	// scenarios
	task automatic t_divide;
		r(CBS_TG_EXT2); r(CBS_TG_NEXT); ei(5'd11);
		run_op(CBS_OP_SDIV_B, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_NEXT); ei(5'd11);
		run_op(CBS_OP_UDIV_B, 1'b0, 8'h00, 4'h2);
		r(CBS_TG_EXT2); r(CBS_TG_NEXT); ei(5'd19);
		run_op(CBS_OP_SDIV_W, 1'b1, 8'h00, 4'h1);
		r(CBS_TG_NEXT); ei(5'd19);
		run_op(CBS_OP_UDIV_W, 1'b0, 8'h00, 4'h0);
		$display("divide test ended");
	endtask
	task automatic t_block;
		r(CBS_TG_EXT2); e(1'b0, 1'b1, 1'b0, CBS_TG_EAS);
		e(1'b0, 1'b1, 1'b0, CBS_TG_EAD);
		repeat (2) begin
			e(1'b0, 1'b1, 1'b0, CBS_TG_EAS);
			e(1'b1, 1'b1, 1'b0, CBS_TG_EAD);
		end
		r(CBS_TG_NEXT);
		run_op(CBS_OP_BLOCK_MOVE, 1'b0, 8'h02, 4'h1);
		r(CBS_TG_EXT2); e(1'b0, 1'b1, 1'b0, CBS_TG_EAS);
		e(1'b0, 1'b1, 1'b0, CBS_TG_EAD);
		r(CBS_TG_NEXT);
		run_op(CBS_OP_BLOCK_MOVE, 1'b0, 8'h00, 4'h0);
		$display("block test ended");
	endtask
	task automatic t_jump_call;
		r(CBS_TG_NEXT); r(CBS_TG_VEC); ei(5'd1); r(CBS_TG_EA);
		run_op(CBS_OP_JMP_VEC8, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_NEXT); e(1'b0, 1'b0, 1'b1, CBS_TG_VEC); r(CBS_TG_VEC);
		ei(5'd1);
		r(CBS_TG_EA);
		run_op(CBS_OP_JMP_VEC8, 1'b1, 8'h00, 4'h2);
		r(CBS_TG_NEXT); r(CBS_TG_EA); e(1'b1, 1'b0, 1'b1, CBS_TG_STK_H);
		e(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
		run_op(CBS_OP_JSR_REG, 1'b1, 8'h00, 4'h1);
		r(CBS_TG_NEXT); r(CBS_TG_EA); e(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
		run_op(CBS_OP_JSR_REG, 1'b0, 8'h00, 4'h0);
		$display("jump and call test ended");
	endtask
	// remaining jump and call forms, load forms except 32-bit displacement, plus an undefined op code
	task automatic t_misc;
		r(CBS_TG_NEXT); r(CBS_TG_EA);
		run_op(CBS_OP_JMP_REG, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_EXT2); ei(5'd1); r(CBS_TG_EA);
		run_op(CBS_OP_JMP_ABS24, 1'b0, 8'h00, 4'h1);
		r(CBS_TG_EXT2); ei(5'd1); r(CBS_TG_EA);
		e(1'b1, 1'b0, 1'b1, CBS_TG_STK_H); e(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
		run_op(CBS_OP_JSR_ABS24, 1'b1, 8'h00, 4'h0);
		r(CBS_TG_NEXT); r(CBS_TG_VEC); e(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
		r(CBS_TG_EA);
		run_op(CBS_OP_JSR_VEC8, 1'b0, 8'h00, 4'h2);
		r(CBS_TG_NEXT); e(1'b0, 1'b0, 1'b1, CBS_TG_VEC); r(CBS_TG_VEC);
		e(1'b1, 1'b0, 1'b1, CBS_TG_STK_H); e(1'b1, 1'b0, 1'b0, CBS_TG_STK_L);
		r(CBS_TG_EA);
		run_op(CBS_OP_JSR_VEC8, 1'b1, 8'h00, 4'h1);
		r(CBS_TG_EXT2); r(CBS_TG_NEXT); r(CBS_TG_EA);
		run_op(CBS_OP_LDC_IND, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_EXT2); r(CBS_TG_EXT3); r(CBS_TG_NEXT); r(CBS_TG_EA);
		run_op(CBS_OP_LDC_D16, 1'b0, 8'h00, 4'h1);
		r(CBS_TG_EXT2); r(CBS_TG_EXT3); r(CBS_TG_NEXT); r(CBS_TG_EA);
		run_op(CBS_OP_LDC_ABS16, 1'b1, 8'h00, 4'h0);
		r(CBS_TG_EXT2); r(CBS_TG_NEXT); ei(5'd1); r(CBS_TG_EA);
		run_op(CBS_OP_LDC_POSTINC, 1'b0, 8'h00, 4'h2);
		r(CBS_TG_EXT2); r(CBS_TG_EXT3); r(CBS_TG_EXT4); r(CBS_TG_NEXT);
		r(CBS_TG_EA);
		run_op(CBS_OP_LDC_ABS32, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_EXT2); r(CBS_TG_NEXT);
		run_op(CBS_OP_LDC_IMM_EXT, 1'b0, 8'h00, 4'h1);
		// undefined code: no column at all, only done
		run_op(cbs_op_e'(5'h1F), 1'b0, 8'h00, 4'h0);
		$display("misc test ended");
	endtask
	task automatic t_pop_order;
		r(CBS_TG_EXT2); e(1'b0, 1'b0, 1'b1, CBS_TG_NEXT); ei(5'd1);
		repeat (3) begin
			e(1'b0, 1'b0, 1'b1, CBS_TG_STK_H);
			r(CBS_TG_STK_L);
		end
		run_op(CBS_OP_POP_MULTI, 1'b0, 8'h03, 4'h1);
		r(CBS_TG_EXT2); r(CBS_TG_EXT3); r(CBS_TG_EXT4); r(CBS_TG_EXT5);
		r(CBS_TG_NEXT); r(CBS_TG_EA);
		run_op(CBS_OP_LDC_D32, 1'b0, 8'h00, 4'h0);
		r(CBS_TG_EXT2); r(CBS_TG_EXT3); r(CBS_TG_NEXT);
		run_op(CBS_OP_CMP_IMM32, 1'b0, 8'h00, 4'h3);
		$display("pop and order test ended");
	endtask
	// reset in mid-divide must clear busy, idle, request, done and target
	task automatic t_reset;
		@(negedge clk_in);
		op_in = CBS_OP_UDIV_W;
		start_in = 1'b1;
		repeat (8) @(negedge clk_in);
		start_in = 1'b0;
		srst_in = 1'b1;
		repeat (10) @(negedge clk_in);
		cmp_bit(busy_out | idle_out | bus_req_out | done_out, 1'b0, "rst");
		cmp_bit(bus_target_out === CBS_TG_NONE, 1'b1, "rst target");
		srst_in = 1'b0;
		// first start one cycle after release must be taken
		r(CBS_TG_NEXT);
		run_op(CBS_OP_NEXT_ONLY, 1'b0, 8'h00, 4'h0);
		$display("reset test ended");
	endtask
	initial begin
		repeat (10) @(negedge clk_in);
		srst_in = 1'b0;
		t_divide();
		t_block();
		t_jump_call();
		t_misc();
		t_pop_order();
		t_reset();
		final_report();
	end
endmodule
